/* src/rpb_pkg.sv */
// Constants, types and default contents of the radar parameter bank.
// Assumes a 100 MHz system clock and a command decoder that hands over one access at a time.
package rpb_pkg;

    // Clock and time base
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned HOLD_UNIT_MS = 100;
    localparam int unsigned HOLD_UNIT_CYCLES = CLK_HZ / 1000 * HOLD_UNIT_MS;
    localparam int unsigned BAUD_SLOW_BPS = 38400;
    localparam int unsigned BAUD_FAST_BPS = 460800;
    localparam int unsigned BAUD_SLOW_CYCLES = CLK_HZ / BAUD_SLOW_BPS;
    localparam int unsigned BAUD_FAST_CYCLES = CLK_HZ / BAUD_FAST_BPS;
    localparam int unsigned BAUD_CNT_W = 12;

    // Array geometry
    localparam int unsigned SLOT_COUNT = 10;
    localparam int unsigned SLOT_W = 16;
    localparam int unsigned BYTE_W = 8;

    // Access classes of the parameter port
    typedef enum logic [2:0] {
        RPB_CLS_ARRAY = 3'h0,
        RPB_CLS_DETECT = 3'h1,
        RPB_CLS_FLASH = 3'h2,
        RPB_CLS_REALTIME = 3'h3,
        RPB_CLS_WRITE = 3'h4
    } rpb_class_type;

    // Array indices: hold slots 0..9, sensitivity slots 10..19
    localparam logic [7:0] IDX_HOLD_FIRST = 8'h00;
    localparam logic [7:0] IDX_SENS_FIRST = 8'h0a;
    localparam logic [7:0] IDX_SENS_LAST = 8'h13;

    // Detection parameter indices
    localparam logic [7:0] IDX_HOLD_INDEX = 8'h00;
    localparam logic [7:0] IDX_SENS_INDEX = 8'h01;
    localparam logic [7:0] IDX_SPEED_SPLIT = 8'h06;
    localparam logic [7:0] HOLD_INDEX_RESET = 8'h01;
    localparam logic [7:0] SENS_INDEX_RESET = 8'h07;
    localparam logic [7:0] SPEED_SPLIT_RESET = 8'h00;
    localparam logic [7:0] INDEX_MAX = 8'h09;
    localparam logic [7:0] SPEED_SPLIT_MAX = 8'h7f;

    // Flash word indices
    localparam logic [7:0] IDX_FIRMWARE = 8'h00;
    localparam logic [7:0] IDX_DEVICE_TYPE = 8'h01;

    // Real-time indices
    localparam logic [7:0] IDX_FLAGS = 8'h00;
    localparam logic [7:0] IDX_SPEED = 8'h01;
    localparam logic [7:0] IDX_MAGNITUDE = 8'h02;
    localparam logic [7:0] IDX_NOISE = 8'h03;
    localparam logic [7:0] IDX_OP_STATE = 8'h04;
    localparam logic [7:0] IDX_HOLD_POT = 8'h05;
    localparam logic [7:0] IDX_SENS_POT = 8'h06;

    // Write command indices
    localparam logic [7:0] IDX_SOFT_RESET = 8'h00;
    localparam logic [7:0] IDX_FACTORY = 8'h01;
    localparam logic [7:0] IDX_BAUD = 8'h02;

    // Flag bit positions
    localparam int unsigned FLAG_DETECT_BIT = 0;
    localparam int unsigned FLAG_APPROACH_BIT = 1;
    localparam int unsigned FLAG_RANGE_BIT = 2;
    localparam int unsigned FLAG_MICRO_BIT = 3;

    // Baud selections
    localparam logic [7:0] BAUD_SEL_SLOW = 8'h00;
    localparam logic [7:0] BAUD_SEL_FAST = 8'h01;

    // Operation states as reported
    localparam logic [7:0] OP_STARTUP = 8'h00;
    localparam logic [7:0] OP_LEARN = 8'h01;
    localparam logic [7:0] OP_RUN = 8'h02;

    typedef logic [SLOT_COUNT-1:0][SLOT_W-1:0] rpb_slots_type;

    // Factory contents, slot 0 in the lowest word
    localparam rpb_slots_type HOLD_DEFAULTS = {
        16'h0640, 16'h0320, 16'h0190, 16'h00c8, 16'h0064,
        16'h0032, 16'h0014, 16'h000a, 16'h0005, 16'h0002
    };
    localparam rpb_slots_type SENS_DEFAULTS = {
        16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h000a,
        16'h000e, 16'h0012, 16'h0016, 16'h001c, 16'h0022
    };

    // Identity words; both values are arbitrary
    localparam logic [15:0] FIRMWARE_DEFAULT = 16'h0100;
    localparam logic [15:0] DEVICE_TYPE_DEFAULT = 16'h00a5;

endpackage

/* src/rpb_bank.sv */
// Parameter bank of the radar sensor: arrays, detection parameters, real-time results.
// Assumes a command decoder in front issuing single-cycle accesses, and a processing
// core that strobes its results once per completed cycle.
`timescale 1ns/1ps
`default_nettype none
module rpb_bank #(
    parameter int unsigned HOLD_UNIT_CYCLES = rpb_pkg::HOLD_UNIT_CYCLES,
    parameter logic [15:0] FIRMWARE_VERSION = rpb_pkg::FIRMWARE_DEFAULT,
    parameter logic [15:0] DEVICE_TYPE = rpb_pkg::DEVICE_TYPE_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Parameter access from the command decoder
    input wire logic req_valid,
    input wire logic req_write,
    input wire rpb_pkg::rpb_class_type req_class,
    input wire logic [7:0] req_index,
    input wire logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [15:0] rsp_rdata,
    // Results from the processing core
    input wire logic proc_done,
    input wire logic proc_detect,
    input wire logic proc_approach,
    input wire logic proc_micro,
    input wire logic [7:0] proc_speed,
    input wire logic [7:0] proc_magnitude,
    input wire logic [7:0] proc_noise,
    input wire logic [7:0] proc_op_state,
    input wire logic [3:0] pot_hold_index,
    input wire logic [3:0] pot_sens_index,
    // Settings towards the core and the serial link
    output logic [15:0] hold_time_value,
    output logic [15:0] sensitivity_value,
    output logic [7:0] speed_split_threshold,
    output logic hold_active,
    output logic baud_fast,
    output logic baud_tick,
    output logic soft_reset_pulse
);
    import rpb_pkg::*;

    // Elaboration-time guard on the time base
    if (HOLD_UNIT_CYCLES < 1) begin : g_bad_unit
        $error("HOLD_UNIT_CYCLES must be at least one");
    end

    localparam logic [31:0] UNIT_LAST = 32'(HOLD_UNIT_CYCLES - 1);
    localparam logic [BAUD_CNT_W-1:0] BAUD_SLOW_LAST = BAUD_CNT_W'(BAUD_SLOW_CYCLES - 1);
    localparam logic [BAUD_CNT_W-1:0] BAUD_FAST_LAST = BAUD_CNT_W'(BAUD_FAST_CYCLES - 1);

    // Whole state of the bank
    typedef struct packed {
        rpb_slots_type hold_slots;
        rpb_slots_type sens_slots;
        logic [7:0] hold_time_index;
        logic [7:0] sensitivity_index;
        logic [7:0] speed_split_threshold;
        logic [7:0] detection_flags;
        logic [7:0] detection_speed;
        logic [7:0] detection_magnitude;
        logic [7:0] noise_level;
        logic [7:0] operation_state;
        logic [7:0] hold_pot_index;
        logic [7:0] sensitivity_pot_index;
        logic baud_fast;
        logic [BAUD_CNT_W-1:0] baud_count;
        logic baud_tick;
        logic [31:0] unit_count;
        logic [15:0] hold_left;
        logic hold_active;
        logic rsp_valid;
        logic rsp_error;
        logic [15:0] rsp_rdata;
        logic soft_reset_pulse;
    } rpb_state_type;

    rpb_state_type state;
    rpb_state_type next_state;

    // Clamp an analogue index to the last slot so a stray code never reads past the array
    function automatic logic [7:0] clamp_index(input logic [7:0] raw);
        clamp_index = (raw > INDEX_MAX) ? INDEX_MAX : raw;
    endfunction

    // Pick one slot of an array by index
    function automatic logic [15:0] pick_slot(input rpb_slots_type slots, input logic [7:0] idx);
        logic [3:0] i;
        i = 4'(clamp_index(idx));
        pick_slot = slots[i];
    endfunction

    // Values that a soft reset or power-on gives to the volatile part
    function automatic rpb_state_type volatile_clear(input rpb_state_type s);
        rpb_state_type r;
        r = s;
        r.detection_flags = '0;
        r.detection_speed = '0;
        r.detection_magnitude = '0;
        r.noise_level = '0;
        r.operation_state = OP_STARTUP;
        r.baud_fast = 1'b0;
        r.baud_count = '0;
        r.baud_tick = 1'b0;
        r.unit_count = '0;
        r.hold_left = '0;
        r.hold_active = 1'b0;
        r.rsp_valid = 1'b0;
        r.rsp_error = 1'b0;
        r.rsp_rdata = '0;
        r.soft_reset_pulse = 1'b0;
        volatile_clear = r;
    endfunction

    // Factory contents of every stored parameter
    function automatic rpb_state_type factory_load(input rpb_state_type s);
        rpb_state_type r;
        r = s;
        r.hold_slots = HOLD_DEFAULTS;
        r.sens_slots = SENS_DEFAULTS;
        r.hold_time_index = HOLD_INDEX_RESET;
        r.sensitivity_index = SENS_INDEX_RESET;
        r.speed_split_threshold = SPEED_SPLIT_RESET;
        factory_load = r;
    endfunction

    // Next state: results capture, timers and parameter access
    always_comb
    begin
        logic [7:0] flags;
        logic unit_tick;
        logic [15:0] selected_hold;
        flags = '0;
        unit_tick = 1'b0;
        selected_hold = '0;
        next_state = state;
        next_state.rsp_valid = 1'b0;
        next_state.rsp_error = 1'b0;
        next_state.soft_reset_pulse = 1'b0;
        next_state.baud_tick = 1'b0;

        // Potentiometer indices follow their inputs, limited to 00..09
        next_state.hold_pot_index = clamp_index({4'h0, pot_hold_index});
        next_state.sensitivity_pot_index = clamp_index({4'h0, pot_sens_index});

        // Snapshot only on a completed cycle so a read never sees a half update
        if (proc_done)
        begin
            flags[FLAG_DETECT_BIT] = proc_detect;
            flags[FLAG_APPROACH_BIT] = proc_detect & proc_approach;
            flags[FLAG_RANGE_BIT] = proc_detect && (state.speed_split_threshold != '0)
                && (proc_speed > state.speed_split_threshold);
            flags[FLAG_MICRO_BIT] = proc_micro;
            next_state.detection_flags = flags;
            next_state.noise_level = proc_noise;
            next_state.operation_state = proc_op_state;
            if (proc_detect)
            begin
                next_state.detection_speed = proc_speed;
                next_state.detection_magnitude = proc_magnitude;
            end
        end

        // Baud enable divider; restarts whenever the rate changes
        if (state.baud_count == (state.baud_fast ? BAUD_FAST_LAST : BAUD_SLOW_LAST))
        begin
            next_state.baud_count = '0;
            next_state.baud_tick = 1'b1;
        end
        else
        begin
            next_state.baud_count = state.baud_count + 1'b1;
        end

        // 100 ms time base for the hold timer
        if (state.unit_count == UNIT_LAST)
        begin
            next_state.unit_count = '0;
            unit_tick = 1'b1;
        end
        else
        begin
            next_state.unit_count = state.unit_count + 1'b1;
        end

        // Hold timer counts the selected slot in 100 ms units, retriggered per detection
        selected_hold = pick_slot(state.hold_slots, state.hold_time_index);
        if (proc_done && proc_detect)
        begin
            next_state.hold_left = selected_hold;
            next_state.hold_active = 1'b1;
        end
        else if (state.hold_active && unit_tick)
        begin
            if (state.hold_left <= 16'h0001)
            begin
                next_state.hold_left = '0;
                next_state.hold_active = 1'b0;
            end
            else
            begin
                next_state.hold_left = state.hold_left - 1'b1;
            end
        end

        // Parameter access, answered one cycle later
        if (req_valid)
        begin
            next_state.rsp_valid = 1'b1;
            case (req_class)
                RPB_CLS_ARRAY:
                begin
                    if (req_index <= IDX_SENS_LAST)
                    begin
                        if (req_index < IDX_SENS_FIRST)
                        begin
                            next_state.rsp_rdata = state.hold_slots[req_index[3:0]];
                            if (req_write)
                            begin
                                next_state.hold_slots[req_index[3:0]] = req_wdata;
                            end
                        end
                        else
                        begin
                            next_state.rsp_rdata =
                                state.sens_slots[4'(req_index - IDX_SENS_FIRST)];
                            if (req_write)
                            begin
                                next_state.sens_slots[4'(req_index - IDX_SENS_FIRST)] = req_wdata;
                            end
                        end
                    end
                    else
                    begin
                        next_state.rsp_rdata = '0;
                        next_state.rsp_error = 1'b1;
                    end
                end
                RPB_CLS_DETECT:
                begin
                    next_state.rsp_rdata = '0;
                    case (req_index)
                        IDX_HOLD_INDEX:
                        begin
                            next_state.rsp_rdata = {8'h00, state.hold_time_index};
                            if (req_write && req_wdata <= {8'h00, INDEX_MAX})
                                next_state.hold_time_index = req_wdata[7:0];
                            else if (req_write)
                                next_state.rsp_error = 1'b1;
                        end
                        IDX_SENS_INDEX:
                        begin
                            next_state.rsp_rdata = {8'h00, state.sensitivity_index};
                            if (req_write && req_wdata <= {8'h00, INDEX_MAX})
                                next_state.sensitivity_index = req_wdata[7:0];
                            else if (req_write)
                                next_state.rsp_error = 1'b1;
                        end
                        IDX_SPEED_SPLIT:
                        begin
                            next_state.rsp_rdata = {8'h00, state.speed_split_threshold};
                            if (req_write && req_wdata <= {8'h00, SPEED_SPLIT_MAX})
                                next_state.speed_split_threshold = req_wdata[7:0];
                            else if (req_write)
                                next_state.rsp_error = 1'b1;
                        end
                        default:
                        begin
                            next_state.rsp_error = 1'b1;
                        end
                    endcase
                end
                RPB_CLS_FLASH:
                begin
                    // Read-only: a write is refused and stores nothing
                    next_state.rsp_error = req_write;
                    case (req_index)
                        IDX_FIRMWARE: next_state.rsp_rdata = FIRMWARE_VERSION;
                        IDX_DEVICE_TYPE: next_state.rsp_rdata = DEVICE_TYPE;
                        default:
                        begin
                            next_state.rsp_rdata = '0;
                            next_state.rsp_error = 1'b1;
                        end
                    endcase
                end
                RPB_CLS_REALTIME:
                begin
                    next_state.rsp_error = req_write;
                    case (req_index)
                        IDX_FLAGS: next_state.rsp_rdata = {8'h00, state.detection_flags};
                        IDX_SPEED: next_state.rsp_rdata = {8'h00, state.detection_speed};
                        IDX_MAGNITUDE: next_state.rsp_rdata = {8'h00, state.detection_magnitude};
                        IDX_NOISE: next_state.rsp_rdata = {8'h00, state.noise_level};
                        IDX_OP_STATE: next_state.rsp_rdata = {8'h00, state.operation_state};
                        IDX_HOLD_POT: next_state.rsp_rdata = {8'h00, state.hold_pot_index};
                        IDX_SENS_POT: next_state.rsp_rdata = {8'h00, state.sensitivity_pot_index};
                        default:
                        begin
                            next_state.rsp_rdata = '0;
                            next_state.rsp_error = 1'b1;
                        end
                    endcase
                end
                RPB_CLS_WRITE:
                begin
                    next_state.rsp_rdata = '0;
                    next_state.rsp_error = !req_write;
                    if (req_write)
                    begin
                        case (req_index)
                            IDX_SOFT_RESET:
                            begin
                                // Stored parameters survive; volatile state and rate do not
                                next_state = volatile_clear(next_state);
                                next_state.rsp_valid = 1'b1;
                                next_state.soft_reset_pulse = 1'b1;
                            end
                            IDX_FACTORY:
                            begin
                                next_state = factory_load(next_state);
                            end
                            IDX_BAUD:
                            begin
                                if (req_wdata == {8'h00, BAUD_SEL_SLOW}
                                    || req_wdata == {8'h00, BAUD_SEL_FAST})
                                begin
                                    next_state.baud_fast = req_wdata[0];
                                    next_state.baud_count = '0;
                                end
                                else
                                begin
                                    next_state.rsp_error = 1'b1;
                                end
                            end
                            default:
                            begin
                                next_state.rsp_error = 1'b1;
                            end
                        endcase
                    end
                end
                default:
                begin
                    next_state.rsp_rdata = '0;
                    next_state.rsp_error = 1'b1;
                end
            endcase
        end
    end

    // State register; power-on gives factory contents and the slow rate
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= volatile_clear(factory_load('0));
        end
        else
        begin
            state <= next_state;
        end
    end

    // Outputs straight from the state
    assign rsp_valid = state.rsp_valid;
    assign rsp_error = state.rsp_error;
    assign rsp_rdata = state.rsp_rdata;
    assign hold_time_value = pick_slot(state.hold_slots, state.hold_time_index);
    assign sensitivity_value = pick_slot(state.sens_slots, state.sensitivity_index);
    assign speed_split_threshold = state.speed_split_threshold;
    assign hold_active = state.hold_active;
    assign baud_fast = state.baud_fast;
    assign baud_tick = state.baud_tick;
    assign soft_reset_pulse = state.soft_reset_pulse;

endmodule
`default_nettype wire

/* verif/rpb_bank_chk.sv */
// Port checker for the radar parameter bank.
// Bound to rpb_bank from the testbench top file; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module rpb_bank_chk
    import rpb_pkg::*;
(
    // Clock, reset and access port
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire rpb_pkg::rpb_class_type req_class,
    input wire logic [7:0] req_index,
    input wire logic [15:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    // Core results and settings
    input wire logic proc_done,
    input wire logic proc_detect,
    input wire logic [15:0] hold_time_value,
    input wire logic [15:0] sensitivity_value,
    input wire logic [7:0] speed_split_threshold,
    input wire logic hold_active,
    input wire logic baud_fast,
    input wire logic baud_tick,
    input wire logic soft_reset_pulse
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Command writes and writes of any class, shared by several properties
    wire logic wcmd = req_valid && req_write && req_class == RPB_CLS_WRITE;
    wire logic wacc = req_valid && req_write;
    // Answers one cycle after every request, never without one
    a_rsp_next: assert property (req_valid |=> rsp_valid) else $error("no answer");
    a_rsp_quiet: assert property (!req_valid |=> !rsp_valid) else $error("stray answer");
    a_flash_ro: assert property (wacc && req_class == RPB_CLS_FLASH |=> rsp_error)
        else $error("flash write taken");
    a_rt_ro: assert property (wacc && req_class == RPB_CLS_REALTIME |=> rsp_error)
        else $error("result write taken");
    a_baud_fast: assert property (wcmd && req_index == IDX_BAUD && req_wdata == 16'h0001
        |=> baud_fast) else $error("fast rate not set");
    a_soft_rst: assert property (wcmd && req_index == IDX_SOFT_RESET
        |=> soft_reset_pulse && !baud_fast) else $error("soft reset missing");
    a_factory_sel: assert property (wcmd && req_index == IDX_FACTORY
        |=> hold_time_value == 16'h0005 && sensitivity_value == 16'h0004)
        else $error("restore wrong");
    a_split_set: assert property (wacc && req_class == RPB_CLS_DETECT
        && req_index == IDX_SPEED_SPLIT && req_wdata <= 16'h007f
        |=> {8'h00, speed_split_threshold} == $past(req_wdata)) else $error("split lost");
    a_hold_start: assert property (proc_done && proc_detect |=> hold_active)
        else $error("hold not started");
    a_tick_gap: assert property (baud_tick && baud_fast |=> !baud_tick [*8])
        else $error("ticks too close");
    // Main scenarios reached
    c_restore: cover property (wcmd && req_index == IDX_FACTORY);
    c_detect: cover property (proc_done && proc_detect);
    c_refuse: cover property (rsp_valid && rsp_error);
endmodule
`default_nettype wire

/* verif/rpb_core_model.sv */
// Model of the processing core that feeds results into the bank.
// Fields are only honest while the strobe is high, as with the real core.
`timescale 1ns/1ps
`default_nettype none
module rpb_core_model (
    // Clock
    input wire logic clk,
    // Results towards the bank
    output logic proc_done,
    output logic proc_detect,
    output logic proc_approach,
    output logic proc_micro,
    output logic [7:0] proc_speed,
    output logic [7:0] proc_magnitude,
    output logic [7:0] proc_noise,
    output logic [7:0] proc_op_state,
    output logic [3:0] pot_hold_index,
    output logic [3:0] pot_sens_index
);
    // Quiet start
    initial
    begin
        {proc_done, proc_detect, proc_approach, proc_micro, proc_speed, proc_magnitude} = '0;
        {proc_noise, proc_op_state, pot_hold_index, pot_sens_index} = '0;
    end
    // One finished cycle; f is micro, approach, detect; garbage after
    task automatic post(input logic [2:0] f, input logic [7:0] sp, mg, nz, st);
        @(posedge clk);
        proc_done <= 1'b1;
        {proc_micro, proc_approach, proc_detect} <= f;
        {proc_speed, proc_magnitude, proc_noise, proc_op_state} <= {sp, mg, nz, st};
        @(posedge clk);
        proc_done <= 1'b0;
        {proc_micro, proc_approach, proc_detect} <= ~f;
        {proc_speed, proc_magnitude, proc_noise, proc_op_state} <= ~{sp, mg, nz, st};
    endtask
    // Potentiometer indices from the converter, may exceed nine
    task automatic pots(input logic [3:0] h, s);
        @(posedge clk);
        pot_hold_index <= h;
        pot_sens_index <= s;
    endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the radar parameter bank.
// Drives the access port itself; the core model supplies results.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rpb_pkg::*;
    // Identity words, arbitrary values
    localparam logic [15:0] FW = 16'h1234;
    localparam logic [15:0] DT = 16'h5a3c;
    logic clk, rst_n, req_valid, req_write, rsp_valid, rsp_error;
    rpb_class_type req_class;
    logic [7:0] req_index, speed_split_threshold, proc_speed, proc_magnitude;
    logic [7:0] proc_noise, proc_op_state;
    logic [15:0] req_wdata, rsp_rdata, hold_time_value, sensitivity_value;
    logic proc_done, proc_detect, proc_approach, proc_micro;
    logic hold_active, baud_fast, baud_tick, soft_reset_pulse;
    logic [3:0] pot_hold_index, pot_sens_index;
    int num_errors = 0;
    int check_count = 0;
    localparam rpb_class_type RT = RPB_CLS_REALTIME;
    rpb_bank #(.HOLD_UNIT_CYCLES(10), .FIRMWARE_VERSION(FW), .DEVICE_TYPE(DT)) dut (.*);
    rpb_core_model core (.*);
    task automatic chk(input logic [16:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One access; a missing answer reads as unknown and never matches
    task automatic acc(input logic w, input rpb_class_type c, input logic [7:0] i,
        input logic [15:0] d, output logic [16:0] r);
        @(posedge clk);
        {req_valid, req_write, req_index, req_wdata} <= {1'b1, w, i, d};
        req_class <= c;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        r = (rsp_valid === 1'b1) ? {rsp_error, rsp_rdata} : 17'bx;
    endtask
    task automatic rd(input rpb_class_type c, input logic [7:0] i, input logic [15:0] e);
        logic [16:0] r;
        acc(1'b0, c, i, 16'h0000, r);
        chk(r, {1'b0, e});
    endtask
    task automatic wr(input rpb_class_type c, input logic [7:0] i, input logic [15:0] d,
        input logic e);
        logic [16:0] r;
        acc(1'b1, c, i, d, r);
        chk(17'(r[16]), 17'(e));
    endtask
    task automatic tally_and_finish();
        $display("Checks made: %0d, mismatches: %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog, well past the sequence length
    initial
    begin
        #100_000;
        num_errors++;
        tally_and_finish();
    end
    // Main sequence
    initial
    begin
        {rst_n, req_valid, req_write, req_index, req_wdata} = '0;
        req_class = RPB_CLS_ARRAY;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 10; k++)
        begin
            rd(RPB_CLS_ARRAY, 8'(k), HOLD_DEFAULTS[k]);
            rd(RPB_CLS_ARRAY, 8'(k + 10), SENS_DEFAULTS[k]);
        end
        rd(RPB_CLS_FLASH, IDX_FIRMWARE, FW);
        rd(RPB_CLS_FLASH, IDX_DEVICE_TYPE, DT);
        wr(RPB_CLS_FLASH, IDX_DEVICE_TYPE, 16'h0000, 1'b1);
        wr(RT, IDX_FLAGS, 16'h0000, 1'b1);
        wr(RPB_CLS_ARRAY, 8'h14, 16'h0000, 1'b1);
        // Selection, then restore undoes writes
        wr(RPB_CLS_ARRAY, 8'h03, 16'h1234, 1'b0);
        wr(RPB_CLS_DETECT, IDX_HOLD_INDEX, 16'h0009, 1'b0);
        wr(RPB_CLS_DETECT, IDX_SENS_INDEX, 16'h000a, 1'b1);
        wr(RPB_CLS_DETECT, IDX_SENS_INDEX, 16'h0000, 1'b0);
        chk(17'(hold_time_value), 17'h0640);
        chk(17'(sensitivity_value), 17'h0022);
        wr(RPB_CLS_WRITE, IDX_FACTORY, 16'h0000, 1'b0);
        rd(RPB_CLS_ARRAY, 8'h03, 16'h0014);
        chk(17'(hold_time_value), 17'h0005);
        // Results: speed 20 over threshold 10, approaching
        wr(RPB_CLS_DETECT, IDX_SPEED_SPLIT, 16'h000a, 1'b0);
        core.pots(4'hc, 4'h3);
        core.post(3'b011, 8'h14, 8'h32, 8'h07, OP_RUN);
        rd(RT, IDX_FLAGS, 16'h0007);
        rd(RT, IDX_SPEED, 16'h0014);
        rd(RT, IDX_MAGNITUDE, 16'h0032);
        rd(RT, IDX_NOISE, 16'h0007);
        rd(RT, IDX_OP_STATE, 16'h0002);
        rd(RT, IDX_HOLD_POT, 16'h0009);
        rd(RT, IDX_SENS_POT, 16'h0003);
        core.post(3'b100, 8'h55, 8'h66, 8'h09, OP_LEARN);
        rd(RT, IDX_FLAGS, 16'h0008);
        rd(RT, IDX_SPEED, 16'h0014);
        rd(RT, IDX_OP_STATE, 16'h0001);
        wr(RPB_CLS_DETECT, IDX_SPEED_SPLIT, 16'h0000, 1'b0);
        core.post(3'b001, 8'h14, 8'h32, 8'h07, OP_STARTUP);
        rd(RT, IDX_FLAGS, 16'h0001);
        // Rate selection, lost on both kinds of reset
        wr(RPB_CLS_WRITE, IDX_BAUD, 16'h0002, 1'b1);
        wr(RPB_CLS_WRITE, IDX_BAUD, 16'h0001, 1'b0);
        chk(17'(baud_fast), 17'h1);
        // Let two fast ticks pass so the tick spacing is watched
        repeat (440) @(posedge clk);
        wr(RPB_CLS_WRITE, IDX_SOFT_RESET, 16'h0000, 1'b0);
        chk(17'(baud_fast), 17'h0);
        rd(RT, IDX_FLAGS, 16'h0000);
        wr(RPB_CLS_WRITE, IDX_BAUD, 16'h0001, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(17'(baud_fast), 17'h0);
        tally_and_finish();
    end
endmodule
bind rpb_bank rpb_bank_chk u_chk (.clk, .rst_n, .req_valid, .req_write, .req_class,
    .req_index, .req_wdata, .rsp_valid, .rsp_error, .proc_done, .proc_detect,
    .hold_time_value, .sensitivity_value, .speed_split_threshold, .hold_active,
    .baud_fast, .baud_tick, .soft_reset_pulse);
`default_nettype wire
